// file: logic/lsa_pkg.sv
package lsa_pkg;
   // ============================================================
   // Widths
   localparam int DATA_W   = 32;
   localparam int OFFSET_W = 16;
   localparam int BYTE_W   = 8;
   localparam int LANES    = 4;
   localparam int LANE_W   = 2;
   localparam int INDEX_W  = 5;
   localparam logic [LANE_W-1:0] LANE_MAX = 2'h3;

   // ============================================================
   // Opcodes and sizes
   typedef enum logic [3:0] {
      LSA_LOAD_BYTE_SIGNED,
      LSA_LOAD_BYTE_ZERO_EXT,
      LSA_LOAD_HALF_SIGNED,
      LSA_LOAD_HALF_ZERO_EXT,
      LSA_LOAD_FULL_WORD,
      LSA_LOAD_PARTIAL_UPPER,
      LSA_LOAD_PARTIAL_LOWER,
      LSA_STORE_BYTE,
      LSA_STORE_HALF,
      LSA_STORE_FULL_WORD,
      LSA_STORE_PARTIAL_UPPER,
      LSA_STORE_PARTIAL_LOWER
   } lsa_op_e;

   // Ordinal equals byte count minus one
   typedef enum logic [1:0] {
      LSA_SZ_BYTE,
      LSA_SZ_HALF,
      LSA_SZ_TRI,
      LSA_SZ_WORD
   } lsa_size_e;

   // ============================================================
   // Shared decodes
   function automatic logic lsa_is_load(input lsa_op_e op);
      lsa_is_load = (op <= LSA_LOAD_PARTIAL_LOWER);
   endfunction : lsa_is_load

   function automatic logic lsa_is_upper(input lsa_op_e op);
      lsa_is_upper = (op == LSA_LOAD_PARTIAL_UPPER) || (op == LSA_STORE_PARTIAL_UPPER);
   endfunction : lsa_is_upper

   function automatic logic lsa_is_lower(input lsa_op_e op);
      lsa_is_lower = (op == LSA_LOAD_PARTIAL_LOWER) || (op == LSA_STORE_PARTIAL_LOWER);
   endfunction : lsa_is_lower
endpackage : lsa_pkg

// file: logic/lsa_lane_map.sv
`timescale 1ns/1ps
`default_nettype none
module lsa_lane_map (
   input  wire lsa_pkg::lsa_size_e             size,
   input  wire logic [lsa_pkg::LANE_W-1:0]     low_address_bits,
   input  wire logic                           big_endian,
   output logic [lsa_pkg::LANES-1:0]           byte_lane_enable,
   output logic [lsa_pkg::LANE_W-1:0]          lowest_lane
);
   // Top lane index, used by the big-endian lowest-lane sum
   localparam logic [1:0] LANE_MAX_C = lsa_pkg::LANE_MAX;

   // ============================================================
   // Legal pairs and little-endian mask
   wire        legal;
   wire [3:0]  count_mask;
   wire [3:0]  le_mask;
   wire [3:0]  be_mask;

   // Illegal pairs give no lanes at all
   assign legal = (size == lsa_pkg::LSA_SZ_BYTE)
               || (size == lsa_pkg::LSA_SZ_HALF && !low_address_bits[0])
               || (size == lsa_pkg::LSA_SZ_TRI  && !low_address_bits[1])
               || (size == lsa_pkg::LSA_SZ_WORD && low_address_bits == 2'h0);
   assign count_mask = 4'((5'h2 << size) - 5'h1);
   // Field starts at the addressed lane, LSB first
   assign le_mask = legal ? 4'(count_mask << low_address_bits) : 4'h0;

   // Big-endian is the mirror image
   genvar g;
   generate
      for (g = 0; g < lsa_pkg::LANES; g++)
      begin : g_mirror
         assign be_mask[g] = le_mask[lsa_pkg::LANES-1-g];
      end
   endgenerate

   assign byte_lane_enable = big_endian ? be_mask : le_mask;
   // Lane holding the field's least significant byte
   assign lowest_lane = big_endian ? 2'(LANE_MAX_C - low_address_bits - size)
                                   : low_address_bits;
endmodule : lsa_lane_map
`default_nettype wire

// file: logic/lsa_load_merge.sv
`timescale 1ns/1ps
`default_nettype none
module lsa_load_merge (
   input  wire lsa_pkg::lsa_op_e               op,
   input  wire lsa_pkg::lsa_size_e             size,
   input  wire logic [lsa_pkg::LANE_W-1:0]     lowest_lane,
   input  wire logic [lsa_pkg::DATA_W-1:0]     mem_word,
   input  wire logic [lsa_pkg::DATA_W-1:0]     merge_base,
   output logic [lsa_pkg::DATA_W-1:0]          result
);
   localparam int BW = lsa_pkg::BYTE_W;
   localparam logic [lsa_pkg::DATA_W-1:0] ONES = 32'hFFFFFFFF;

   // ============================================================
   // Field extraction and shift amounts
   wire [5:0]                  down_sh;
   wire [5:0]                  gap_sh;
   wire [5:0]                  cnt_sh;
   wire [lsa_pkg::DATA_W-1:0]  field;
   wire [lsa_pkg::DATA_W-1:0]  keep_low;
   wire [lsa_pkg::DATA_W-1:0]  low_mask;

   assign down_sh  = 6'(BW * lowest_lane);
   assign gap_sh   = 6'(BW * (3 - size));
   assign cnt_sh   = 6'(BW * (size + 1));
   assign field    = mem_word >> down_sh;
   assign keep_low = ONES >> cnt_sh;
   assign low_mask = ONES >> gap_sh;

   // ============================================================
   // Result by opcode
   always_comb
   begin
      case (op)
         lsa_pkg::LSA_LOAD_BYTE_SIGNED:   result = {{24{field[7]}}, field[7:0]};
         lsa_pkg::LSA_LOAD_HALF_SIGNED:   result = {{16{field[15]}}, field[15:0]};
         lsa_pkg::LSA_LOAD_BYTE_ZERO_EXT: result = {24'h000000, field[7:0]};
         lsa_pkg::LSA_LOAD_HALF_ZERO_EXT: result = {16'h0000, field[15:0]};
         // Field lands in the leftmost bytes, rest kept
         lsa_pkg::LSA_LOAD_PARTIAL_UPPER:
            result = (field << gap_sh) | (merge_base & keep_low);
         // Field lands in the rightmost bytes, rest kept
         lsa_pkg::LSA_LOAD_PARTIAL_LOWER:
            result = (field & low_mask) | (merge_base & ~low_mask);
         default:                         result = mem_word;
      endcase
   end
endmodule : lsa_load_merge
`default_nettype wire

// file: logic/lsa_align.sv
`timescale 1ns/1ps
`default_nettype none
module lsa_align (
   input  wire logic                           core_clk,
   input  wire logic                           rst_b,
   // Pipeline request
   input  wire logic                           req_valid,
   output logic                                req_ready,
   input  wire lsa_pkg::lsa_op_e               req_op,
   input  wire logic [lsa_pkg::DATA_W-1:0]     base_value,
   input  wire logic [lsa_pkg::OFFSET_W-1:0]   offset_imm,
   input  wire logic [lsa_pkg::DATA_W-1:0]     target_value,
   input  wire logic [lsa_pkg::INDEX_W-1:0]    target_register,
   // Mode
   input  wire logic                           kernel_big_endian,
   input  wire logic                           reverse_endian_user,
   input  wire logic                           user_mode,
   // Memory side
   output logic                                mem_read,
   output logic                                mem_write,
   output logic [lsa_pkg::DATA_W-1:0]          mem_addr,
   output logic [lsa_pkg::LANES-1:0]           byte_lane_enable,
   output logic [lsa_pkg::DATA_W-1:0]          mem_wdata,
   input  wire logic                           mem_rdata_valid,
   input  wire logic [lsa_pkg::DATA_W-1:0]     mem_rdata,
   // Results
   output logic                                address_error,
   output logic                                load_result_valid,
   output logic [lsa_pkg::DATA_W-1:0]          load_result,
   output logic [lsa_pkg::INDEX_W-1:0]         load_result_index
);
   localparam int BW = lsa_pkg::BYTE_W;

   // ============================================================
   // Address and ordering
   wire                          accept;
   wire [lsa_pkg::DATA_W-1:0]    eff_addr;
   wire [1:0]                    low_address_bits;
   wire                          big_endian;
   wire                          is_load;
   wire                          is_upper;
   wire                          is_lower;
   wire                          from_addr;
   wire                          misaligned;
   lsa_pkg::lsa_size_e           size;
   wire [1:0]                    field_lo;
   wire [3:0]                    next_lanes;
   wire [1:0]                    lowest_lane;
   wire [lsa_pkg::DATA_W-1:0]    store_field;
   wire [lsa_pkg::DATA_W-1:0]    next_wdata;
   wire                          fwd_hit;

   assign accept = req_valid && req_ready;
   // Base plus sign-extended offset
   assign eff_addr = base_value + {{(lsa_pkg::DATA_W-lsa_pkg::OFFSET_W){offset_imm[15]}},
                                   offset_imm};
   assign low_address_bits = eff_addr[1:0];
   // User accesses flip with the reverse bit, else kernel order
   assign big_endian = (user_mode && reverse_endian_user) ? !kernel_big_endian
                                                          : kernel_big_endian;
   assign is_load  = lsa_pkg::lsa_is_load(req_op);
   assign is_upper = lsa_pkg::lsa_is_upper(req_op);
   assign is_lower = lsa_pkg::lsa_is_lower(req_op);
   // Partial field runs from the addressed byte to the word end, or from the word start
   assign from_addr = (is_upper && big_endian) || (is_lower && !big_endian);

   // Size from opcode, and for partial ops from the low address bits
   always_comb
   begin
      case (req_op)
         lsa_pkg::LSA_LOAD_BYTE_SIGNED,
         lsa_pkg::LSA_LOAD_BYTE_ZERO_EXT,
         lsa_pkg::LSA_STORE_BYTE:          size = lsa_pkg::LSA_SZ_BYTE;
         lsa_pkg::LSA_LOAD_HALF_SIGNED,
         lsa_pkg::LSA_LOAD_HALF_ZERO_EXT,
         lsa_pkg::LSA_STORE_HALF:          size = lsa_pkg::LSA_SZ_HALF;
         lsa_pkg::LSA_LOAD_FULL_WORD,
         lsa_pkg::LSA_STORE_FULL_WORD:     size = lsa_pkg::LSA_SZ_WORD;
         default:
            size = from_addr ? lsa_pkg::lsa_size_e'(2'h3 - low_address_bits)
                             : lsa_pkg::lsa_size_e'(low_address_bits);
      endcase
   end

   // Presented address names the field's lowest byte
   assign field_lo = ((is_upper || is_lower) && !from_addr) ? 2'h0 : low_address_bits;

   // Misaligned half or full word is trapped, never issued
   // Partial ops also decode to a half size, but never trap
   assign misaligned = !is_upper && !is_lower
                    && ((size == lsa_pkg::LSA_SZ_HALF && low_address_bits[0])
                        || ((req_op == lsa_pkg::LSA_LOAD_FULL_WORD
                             || req_op == lsa_pkg::LSA_STORE_FULL_WORD)
                            && low_address_bits != 2'h0));

   lsa_lane_map u_lane_map (
      .size             (size),
      .low_address_bits (field_lo),
      .big_endian       (big_endian),
      .byte_lane_enable (next_lanes),
      .lowest_lane      (lowest_lane)
   );

   // ============================================================
   // Store data placement
   // Upper partial takes the source's top bytes
   assign store_field = is_upper ? (target_value >> 6'(BW * (3 - size))) : target_value;
   // Field LSB goes to its lowest lane
   assign next_wdata = store_field << 6'(BW * lowest_lane);

   // ============================================================
   // Request register
   // One load outstanding keeps results in order for forwarding
   logic                        pend_valid;
   lsa_pkg::lsa_op_e            pend_op;
   lsa_pkg::lsa_size_e          pend_size;
   logic [1:0]                  pend_lowest;
   logic [lsa_pkg::DATA_W-1:0]  pend_base;
   logic [lsa_pkg::INDEX_W-1:0] pend_index;
   logic                        pend_fwd;
   logic                        prev_load;
   logic [lsa_pkg::INDEX_W-1:0] prev_index;
   lsa_pkg::lsa_op_e            result_op;
   wire  [lsa_pkg::DATA_W-1:0]  merged;
   wire                         issue;

   assign req_ready = !pend_valid;
   assign issue     = accept && !misaligned;
   // Partial load right after a load of the same target forwards it
   assign fwd_hit   = (is_upper || is_lower) && prev_load && prev_index == target_register;

   // Memory strobes are one-cycle pulses
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mem_read         <= 1'b0;
         mem_write        <= 1'b0;
         address_error    <= 1'b0;
         mem_addr         <= '0;
         byte_lane_enable <= '0;
         mem_wdata        <= '0;
      end
      else
      begin
         mem_read      <= issue && is_load;
         mem_write     <= issue && !is_load;
         address_error <= accept && misaligned;
         if (issue)
         begin
            mem_addr         <= {eff_addr[lsa_pkg::DATA_W-1:2], field_lo};
            byte_lane_enable <= next_lanes;
            mem_wdata        <= is_load ? '0 : next_wdata;
         end
      end
   end

   // Pending load context
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pend_valid  <= 1'b0;
         pend_op     <= lsa_pkg::LSA_LOAD_FULL_WORD;
         pend_size   <= lsa_pkg::LSA_SZ_WORD;
         pend_lowest <= 2'h0;
         pend_base   <= '0;
         pend_index  <= '0;
         pend_fwd    <= 1'b0;
         prev_load   <= 1'b0;
         prev_index  <= '0;
      end
      else
      begin
         if (issue && is_load)
         begin
            pend_valid  <= 1'b1;
            pend_op     <= req_op;
            pend_size   <= size;
            pend_lowest <= lowest_lane;
            pend_base   <= target_value;
            pend_index  <= target_register;
            pend_fwd    <= fwd_hit;
         end
         else if (mem_rdata_valid)
            pend_valid <= 1'b0;
         if (accept)
         begin
            prev_load  <= issue && is_load;
            prev_index <= target_register;
         end
      end
   end

   // Last result is the pending value of the preceding load
   lsa_load_merge u_load_merge (
      .op          (pend_op),
      .size        (pend_size),
      .lowest_lane (pend_lowest),
      .mem_word    (mem_rdata),
      .merge_base  (pend_fwd ? load_result : pend_base),
      .result      (merged)
   );

   // Load result register
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         load_result_valid <= 1'b0;
         load_result       <= '0;
         load_result_index <= '0;
         result_op         <= lsa_pkg::LSA_LOAD_FULL_WORD;
      end
      else
      begin
         load_result_valid <= pend_valid && mem_rdata_valid;
         if (pend_valid && mem_rdata_valid)
         begin
            load_result       <= merged;
            load_result_index <= pend_index;
            result_op         <= pend_op;
         end
      end
   end

   // ============================================================
   // Assertions
   property p_eff_addr;
      @(posedge core_clk) disable iff (!rst_b)
      issue |=> mem_addr[31:2] == $past(eff_addr[31:2]);
   endproperty
   a_eff_addr: assert property (p_eff_addr) else $error("word address mismatch");

   property p_legal_lanes;
      @(posedge core_clk) disable iff (!rst_b)
      (mem_read || mem_write) |-> byte_lane_enable != 4'h0
         && $countones(byte_lane_enable + (byte_lane_enable & -byte_lane_enable)) <= 1;
   endproperty
   a_legal_lanes: assert property (p_legal_lanes) else $error("illegal lanes");

   property p_word_store;
      @(posedge core_clk) disable iff (!rst_b)
      issue && req_op == lsa_pkg::LSA_STORE_FULL_WORD
         |=> mem_write && byte_lane_enable == 4'hF && mem_wdata == $past(target_value);
   endproperty
   a_word_store: assert property (p_word_store) else $error("word store wrong");

   property p_misalign;
      @(posedge core_clk) disable iff (!rst_b)
      accept && misaligned |=> address_error && !mem_read && !mem_write;
   endproperty
   a_misalign: assert property (p_misalign) else $error("misaligned access issued");

   property p_byte_le;
      @(posedge core_clk) disable iff (!rst_b)
      issue && req_op == lsa_pkg::LSA_STORE_BYTE && !big_endian
         |=> byte_lane_enable == 4'(4'h1 << $past(low_address_bits));
   endproperty
   a_byte_le: assert property (p_byte_le) else $error("little byte lane");

   property p_byte_be;
      @(posedge core_clk) disable iff (!rst_b)
      issue && req_op == lsa_pkg::LSA_STORE_BYTE && big_endian
         |=> byte_lane_enable == 4'(4'h8 >> $past(low_address_bits));
   endproperty
   a_byte_be: assert property (p_byte_be) else $error("big byte lane");

   property p_reverse;
      @(posedge core_clk) disable iff (!rst_b)
      issue && req_op == lsa_pkg::LSA_STORE_HALF && user_mode && reverse_endian_user
         && !kernel_big_endian && low_address_bits == 2'h0 |=> byte_lane_enable == 4'hC;
   endproperty
   a_reverse: assert property (p_reverse) else $error("reverse ordering ignored");

   property p_sign_ext;
      @(posedge core_clk) disable iff (!rst_b)
      load_result_valid && result_op == lsa_pkg::LSA_LOAD_BYTE_SIGNED
         |-> load_result[31:8] == {24{load_result[7]}};
   endproperty
   a_sign_ext: assert property (p_sign_ext) else $error("byte not sign-extended");

   property p_zero_ext;
      @(posedge core_clk) disable iff (!rst_b)
      load_result_valid && result_op == lsa_pkg::LSA_LOAD_HALF_ZERO_EXT
         |-> load_result[31:16] == 16'h0000;
   endproperty
   a_zero_ext: assert property (p_zero_ext) else $error("half not zero-extended");

   c_load:  cover property (@(posedge core_clk) disable iff (!rst_b) load_result_valid);
   c_store: cover property (@(posedge core_clk) disable iff (!rst_b) mem_write);
   c_error: cover property (@(posedge core_clk) disable iff (!rst_b) address_error);
   c_fwd:   cover property (@(posedge core_clk) disable iff (!rst_b) issue && fwd_hit);
endmodule : lsa_align
`default_nettype wire

// file: bench/lsa_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Data memory stand-in: one read at a time, latency of 1 to 3 cycles
module lsa_mem_model (
   input  wire logic                       core_clk,
   input  wire logic                       rst_b,
   input  wire logic                       mem_read,
   input  wire logic [lsa_pkg::DATA_W-1:0] mem_addr,
   output logic                            mem_rdata_valid,
   output logic [lsa_pkg::DATA_W-1:0]      mem_rdata
);
   int unsigned n_reads = 0;
   int unsigned wait_cnt = 0;
   logic [31:0] addr_q = 32'h0;

   // Contents from the word address, so the bench can predict every read
   function automatic logic [31:0] word_at(input logic [31:0] a);
      word_at = ({a[31:2], 2'h0} * 32'h9E3779B1) ^ 32'hC3A50F96;
   endfunction : word_at

   initial mem_rdata_valid = 1'b0;
   initial mem_rdata = 32'hA5A5A5A5;

   // Data toggles outside replies so stale words never look valid
   always @(negedge core_clk or negedge rst_b)
   begin
      mem_rdata_valid = 1'b0;
      mem_rdata = ~mem_rdata;
      if (!rst_b)
         wait_cnt = 0;
      else
      begin
         if (wait_cnt != 0)
         begin
            wait_cnt = wait_cnt - 1;
            mem_rdata_valid = (wait_cnt == 0);
            if (wait_cnt == 0)
               mem_rdata = word_at(addr_q);
         end
         if (mem_read)
         begin
            wait_cnt = 1 + (n_reads % 3);
            n_reads = n_reads + 1;
            addr_q = mem_addr;
         end
      end
   end
endmodule : lsa_mem_model
`default_nettype wire

// file: bench/tb_lsa_align.sv
`timescale 1ns/1ps
`default_nettype none
module tb_lsa_align;
   typedef struct packed {
      logic [63:0] t;
      logic [2:0]  kind;
      logic [31:0] addr;
      logic [3:0]  lanes;
      logic [31:0] wdata;
   } lsa_note_s;
   typedef struct packed {
      logic [31:0] data;
      logic [4:0]  idx;
   } lsa_res_s;

   // ============================================================
   // Stimulus and observed signals
   logic              core_clk = 1'b0;
   logic              rst_b = 1'b0;
   logic              req_valid = 1'b0;
   lsa_pkg::lsa_op_e  req_op = lsa_pkg::LSA_STORE_BYTE;
   logic [31:0]       base_value = 32'h0;
   logic [15:0]       offset_imm = 16'h0;
   logic [31:0]       target_value = 32'h0;
   logic [4:0]        target_register = 5'h0;
   logic              kernel_big_endian = 1'b0;
   logic              reverse_endian_user = 1'b0;
   logic              user_mode = 1'b0;
   wire logic         req_ready, mem_read, mem_write, mem_rdata_valid;
   wire logic         address_error, load_result_valid;
   wire logic [31:0]  mem_addr, mem_wdata, mem_rdata, load_result;
   wire logic [3:0]   byte_lane_enable;
   wire logic [4:0]   load_result_index;
   int                seed = 3;
   int                n_fail = 0;
   int                tests_run = 0;
   lsa_note_s         q_iss[$];
   lsa_res_s          q_res[$];
   logic [31:0]       last_res = 32'h0;
   logic [4:0]        last_idx = 5'h0;
   logic              fw_ok = 1'b0;

   always #4 core_clk = ~core_clk;

   lsa_align u_dut (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .base_value(base_value),
      .offset_imm(offset_imm), .target_value(target_value),
      .target_register(target_register), .kernel_big_endian(kernel_big_endian),
      .reverse_endian_user(reverse_endian_user), .user_mode(user_mode),
      .mem_read(mem_read), .mem_write(mem_write), .mem_addr(mem_addr),
      .byte_lane_enable(byte_lane_enable), .mem_wdata(mem_wdata),
      .mem_rdata_valid(mem_rdata_valid), .mem_rdata(mem_rdata),
      .address_error(address_error), .load_result_valid(load_result_valid),
      .load_result(load_result), .load_result_index(load_result_index));

   lsa_mem_model u_mem (.core_clk(core_clk), .rst_b(rst_b), .mem_read(mem_read),
      .mem_addr(mem_addr), .mem_rdata_valid(mem_rdata_valid), .mem_rdata(mem_rdata));

   // ============================================================
   // Compare tasks and verdict
   task automatic chk_issue(input lsa_note_s g, input lsa_note_s e);
      logic [31:0] bm;
      bm = {{8{e.lanes[3]}}, {8{e.lanes[2]}}, {8{e.lanes[1]}}, {8{e.lanes[0]}}};
      if (e.kind != 3'h2)
         bm = 32'h0;
      if (e.kind == 3'h4)
         {g.addr, g.lanes, e.addr, e.lanes} = '0;
      g.wdata = g.wdata & bm;
      e.wdata = e.wdata & bm;
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected issue at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk_issue

   task automatic chk_load(input lsa_res_s g, input lsa_res_s e);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected load at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk_load

   task automatic wrap_up;
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // ============================================================
   // One request: predict, drive on the falling edge, hold until taken
   task automatic issue(input lsa_pkg::lsa_op_e op, input logic [2:0] mode,
                        input logic [1:0] lo);
      logic [31:0] ea, fld, rd, mb, nm, res;
      logic [3:0]  lm;
      logic        big, up, dn, ld, err;
      int          n, st, lw, k;
      lsa_note_s   e;
      {kernel_big_endian, reverse_endian_user, user_mode} = mode;
      offset_imm = 16'($random(seed));
      base_value = $random(seed);
      base_value[1:0] = lo - offset_imm[1:0];
      target_value = $random(seed);
      target_register = 5'($random(seed)) & 5'h03;
      req_op = op;
      ea = base_value + {{16{offset_imm[15]}}, offset_imm};
      big = (mode[1] && mode[0]) ? !mode[2] : mode[2];
      ld = (op <= lsa_pkg::LSA_LOAD_PARTIAL_LOWER);
      up = (op == lsa_pkg::LSA_LOAD_PARTIAL_UPPER) || (op == lsa_pkg::LSA_STORE_PARTIAL_UPPER);
      dn = (op == lsa_pkg::LSA_LOAD_PARTIAL_LOWER) || (op == lsa_pkg::LSA_STORE_PARTIAL_LOWER);
      n = (op <= lsa_pkg::LSA_LOAD_BYTE_ZERO_EXT || op == lsa_pkg::LSA_STORE_BYTE) ? 1 :
          (op <= lsa_pkg::LSA_LOAD_HALF_ZERO_EXT || op == lsa_pkg::LSA_STORE_HALF) ? 2 : 4;
      st = lo;
      if (up || dn)
      begin
         st = ((up && big) || (dn && !big)) ? lo : 0;
         n = ((up && big) || (dn && !big)) ? 4 - lo : lo + 1;
      end
      err = !(up || dn) && ((n == 2 && lo[0]) || (n == 4 && lo != 2'h0));
      lm = 4'(((5'h01 << n) - 5'h01) << st);
      lw = big ? 4 - st - n : st;
      k = 8 * (4 - n);
      nm = (n == 4) ? 32'hFFFFFFFF : (32'h1 << (8 * n)) - 32'h1;
      e.kind = err ? 3'h4 : ld ? 3'h1 : 3'h2;
      e.addr = {ea[31:2], 2'(st)};
      e.lanes = big ? {lm[0], lm[1], lm[2], lm[3]} : lm;
      e.wdata = (((up ? target_value >> k : target_value) & nm) << (8 * lw));
      rd = u_mem.word_at(ea);
      fld = (rd >> (8 * lw)) & nm;
      mb = (fw_ok && target_register == last_idx) ? last_res : target_value;
      case (op)
         lsa_pkg::LSA_LOAD_BYTE_SIGNED: res = {{24{fld[7]}}, fld[7:0]};
         lsa_pkg::LSA_LOAD_HALF_SIGNED: res = {{16{fld[15]}}, fld[15:0]};
         lsa_pkg::LSA_LOAD_PARTIAL_UPPER: res = (fld << k) | (mb & ~(nm << k));
         lsa_pkg::LSA_LOAD_PARTIAL_LOWER: res = fld | (mb & ~nm);
         default: res = fld;
      endcase
      req_valid = 1'b1;
      for (int i = 0; i < 50 && req_ready !== 1'b1; i++)
         @(negedge core_clk);
      @(posedge core_clk);
      e.t = $time + 4;
      q_iss.push_back(e);
      if (ld && !err)
      begin
         q_res.push_back({res, target_register});
         last_res = res;
      end
      fw_ok = ld && !err;
      last_idx = target_register;
      @(negedge core_clk);
   endtask : issue

   // ============================================================
   // Watcher: results are taken where settled, half a cycle after the edge
   always @(negedge core_clk)
   begin : mon
      lsa_note_s g, e;
      lsa_res_s  x;
      g = {$time, address_error, mem_write, mem_read, mem_addr, byte_lane_enable, mem_wdata};
      if (rst_b && (mem_read || mem_write || address_error))
      begin
         e = (q_iss.size() != 0) ? q_iss.pop_front() : '0;
         chk_issue(g, e);
      end
      if (rst_b && load_result_valid)
      begin
         x = (q_res.size() != 0) ? q_res.pop_front() : '0;
         chk_load({load_result, load_result_index}, x);
      end
   end

   // Cuts a hang short; the sweep needs about nine hundred cycles
   initial
   begin
      #(8 * 40000);
      n_fail++;
      wrap_up();
   end

   // ============================================================
   // Main sequence: every mode, every opcode, every low address
   initial
   begin
      repeat (16) @(negedge core_clk);
      chk_load({load_result, load_result_index}, '0);
      rst_b = 1'b1;
      for (int m = 0; m < 8; m++)
         for (int o = 0; o < 12; o++)
            for (int lo = 0; lo < 4; lo++)
               issue(lsa_pkg::lsa_op_e'(o), 3'(m), 2'(lo));
      req_valid = 1'b0;
      repeat (10) @(negedge core_clk);
      chk_load(37'(q_iss.size() + q_res.size()), '0);
      wrap_up();
   end
endmodule : tb_lsa_align
`default_nettype wire
